/* File: rtl/mwola_pkg.sv */
package mwola_pkg;
  // sample and coefficient formats (two's complement, coefficients q1.15)
  localparam int SAMPLE_W = 16;
  localparam int COEF_W = 16;
  localparam int COEF_FRAC = 15;
  localparam int ACC_W = 2 * SAMPLE_W + 2;
  localparam int IDX_W = 16;
  // default frame and window sizes (48 kHz output, 20 ms frames)
  localparam int FRAME_LEN_DEF = 960;
  localparam int WIN_HALF_DEF = 960;
  localparam int COMP_DEPTH_DEF = 640;
  // fixed decimation for the 32 kHz interleaved case
  localparam logic [3:0] DEC_STEP_32K = 4'h3;
  localparam logic [3:0] DEC_OFFSET_32K = 4'h1;
  // share of the frame kept for onset look-ahead
  localparam int PREMEM_NUM = 7;
  localparam int PREMEM_DEN = 32;
  // gain of one in q1.15, used while attenuation is off
  localparam logic [COEF_W-1:0] GAIN_UNITY = 16'h7fff;

  typedef enum logic [1:0] {
    MWOLA_CLEAR,
    MWOLA_LOAD,
    MWOLA_RUN
  } mwola_state_t;

  // one decoded block position: source sample, window slot, sign, table
  typedef struct packed {
    logic neg;
    logic comp;
    logic [IDX_W-1:0] src;
    logic [IDX_W-1:0] widx;
  } mwola_map_t;
endpackage : mwola_pkg

/* File: rtl/mwola_mem.sv */
`timescale 1ns/1ns
`default_nettype none

// simple dual-port memory, read data registered
module mwola_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 960
) (
  // clock
  input wire logic clock_i,
  // write port
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // read port
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // contents have no reset; callers clear what must start at zero
  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule : mwola_mem

`default_nettype wire

/* File: rtl/mwola_unfold.sv */
`timescale 1ns/1ns
`default_nettype none

module mwola_unfold #(
  parameter int FRAME_MAX = mwola_pkg::FRAME_LEN_DEF,
  parameter int WIN_HALF = mwola_pkg::WIN_HALF_DEF,
  parameter int COMP_DEPTH = mwola_pkg::COMP_DEPTH_DEF
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // frame setup, sampled at the first sample of a frame
  input wire logic [15:0] frame_len_i,
  input wire logic [3:0] dec_step_i,
  input wire logic [3:0] dec_offset_i,
  input wire logic rate32_i,
  input wire logic frame_good_i,
  input wire logic bitrate_low_i,
  // window table load
  input wire logic win_we_i,
  input wire logic [$clog2(2*WIN_HALF+COMP_DEPTH)-1:0] win_addr_i,
  input wire logic [mwola_pkg::COEF_W-1:0] win_data_i,
  // frame from the inverse transform
  input wire logic in_valid_i,
  input wire logic [mwola_pkg::SAMPLE_W-1:0] in_data_i,
  output logic in_ready_o,
  // raw look-ahead memory for onset analysis
  output logic premem_valid_o,
  output logic [mwola_pkg::SAMPLE_W-1:0] premem_data_o,
  // gain exchange with the echo-zone stage
  output logic gain_req_o,
  output logic [mwola_pkg::SAMPLE_W-1:0] gain_sample_o,
  input wire logic echo_zone_i,
  input wire logic [mwola_pkg::COEF_W-1:0] gain_lb_i,
  input wire logic [mwola_pkg::COEF_W-1:0] gain_hb_i,
  // decoded output
  output logic out_valid_o,
  output logic [mwola_pkg::SAMPLE_W-1:0] out_data_o,
  output logic atten_en_o
);
  localparam int SW = mwola_pkg::SAMPLE_W;
  localparam int AW = mwola_pkg::ACC_W;
  localparam int IW = mwola_pkg::IDX_W;
  localparam int WIN_DEPTH = 2 * WIN_HALF + COMP_DEPTH;
  localparam int FAW = $clog2(FRAME_MAX);
  localparam int WAW = $clog2(WIN_DEPTH);

  // window must cover the largest frame, frame must split in quarters
  if (WIN_HALF < FRAME_MAX || FRAME_MAX % 4 != 0) begin : g_bad_size
    $error("mwola_unfold: window shorter than frame or frame not in quarters");
  end

  function automatic logic [SW-1:0] sat(input logic signed [AW-1:0] v);
    logic signed [AW-1:0] hi;
    logic signed [AW-1:0] lo;
    hi = AW'(signed'({1'b0, {(SW-1){1'b1}}}));
    lo = -hi - AW'(signed'(1));
    if (v > hi) return hi[SW-1:0];
    if (v < lo) return lo[SW-1:0];
    return v[SW-1:0];
  endfunction : sat

  // where block position k takes its sample and its window coefficient
  function automatic mwola_pkg::mwola_map_t unfold_map(input int k, input int l,
      input int nw, input int df, input int d, input logic r32);
    mwola_pkg::mwola_map_t r;
    int h;
    int q;
    int j;
    int m;
    int src;
    int wi;
    logic comp;
    logic odd;
    h = l / 2;
    q = (k >= 3 * h) ? 3 : (k >= 2 * h) ? 2 : (k >= h) ? 1 : 0;
    j = k - q * h;
    m = j / 2;
    odd = j[0];
    comp = 1'b0;
    src = (q == 0) ? h + j : (q == 1) ? l - j - 1 : (q == 2) ? h - j - 1 : j;
    wi = 0;
    if (!r32) begin
      unique case (q)
        0: wi = j * df + d;
        1: wi = nw / 2 - 1 + (j + 1) * df - d;
        2: wi = nw + j * df + d;
        default: wi = 3 * nw / 2 - 1 + (j + 1) * df - d;
      endcase
      wi = 2 * nw - wi - 1; // time reversal of the stored window
    end else begin
      // h equals the 16 kHz frame length here
      comp = (q == 0 || q == 2) ? odd : !odd; // interleave tables
      unique case (q)
        0: wi = odd ? 2 * h - m - 1 : (2 * h - m) * df - 1 - d;
        1: wi = odd ? (3 * h / 2 - 1 - m) * df + d : 3 * h / 2 - 1 - m;
        2: wi = odd ? h - m : (h - m) * df - d;
        default: wi = odd ? (h / 2 - m - 1) * df + d : h / 2 - m - 1;
      endcase
      if (q == 1 && odd) begin
        src = l - j;
      end
    end
    r.neg = (q != 0);
    r.comp = comp;
    r.src = IW'(src);
    r.widx = IW'(wi);
    return r;
  endfunction : unfold_map

  mwola_pkg::mwola_state_t state_q, state_d;
  logic [IW-1:0] cnt_q, cnt_d;
  logic [IW-1:0] len_q;
  logic [3:0] step_q;
  logic [3:0] offs_q;
  logic r32_q;
  logic good_q;
  logic prev_good_q;
  logic low_rate_q;
  logic v1_q;
  logic neg1_q;
  logic [IW-1:0] k1_q;
  logic v2_q;
  logic [SW-1:0] ola_q;
  logic [SW-1:0] hist1_q;
  logic [SW-1:0] hist2_q;

  // setup, remembered for the whole frame
  wire first_in = in_valid_i && in_ready_o && cnt_q == '0;
  wire [3:0] df_w = rate32_i ? mwola_pkg::DEC_STEP_32K : dec_step_i;
  wire [3:0] d_w = rate32_i ? mwola_pkg::DEC_OFFSET_32K : dec_offset_i;
  wire [IW-1:0] two_len = IW'({len_q, 1'b0});
  wire [IW-1:0] premem_len = IW'((32'(len_q) * mwola_pkg::PREMEM_NUM)
                                 / mwola_pkg::PREMEM_DEN);

  // sequencing: clear overlap memory, load frame, run 2L positions
  assign in_ready_o = state_q == mwola_pkg::MWOLA_LOAD;
  wire run_last = cnt_q == two_len - IW'(1);
  wire load_last = in_valid_i && cnt_q == frame_len_i - IW'(1);
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      mwola_pkg::MWOLA_CLEAR: begin
        cnt_d = cnt_q + IW'(1);
        if (cnt_q == IW'(FRAME_MAX - 1)) begin
          state_d = mwola_pkg::MWOLA_LOAD;
          cnt_d = '0;
        end
      end
      mwola_pkg::MWOLA_LOAD: begin
        if (in_valid_i) cnt_d = cnt_q + IW'(1);
        if (load_last) begin
          state_d = mwola_pkg::MWOLA_RUN;
          cnt_d = '0;
        end
      end
      mwola_pkg::MWOLA_RUN: begin
        cnt_d = cnt_q + IW'(1);
        if (run_last) begin
          state_d = mwola_pkg::MWOLA_LOAD;
          cnt_d = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_q <= mwola_pkg::MWOLA_CLEAR;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // frame setup and receive history; previous-good starts false
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      len_q <= IW'(FRAME_MAX);
      step_q <= '0;
      offs_q <= '0;
      r32_q <= 1'b0;
      good_q <= 1'b0;
      prev_good_q <= 1'b0;
      low_rate_q <= 1'b0;
    end else if (first_in) begin
      len_q <= frame_len_i;
      step_q <= df_w;
      offs_q <= d_w;
      r32_q <= rate32_i;
      good_q <= frame_good_i;
      prev_good_q <= good_q;
      low_rate_q <= bitrate_low_i;
    end
  end
  assign atten_en_o = good_q && prev_good_q && low_rate_q;

  // stage 0: map the running position onto frame and window
  wire mwola_pkg::mwola_map_t map_w = unfold_map(int'(cnt_q), int'(len_q),
      WIN_HALF, int'(step_q), int'(offs_q), r32_q);
  wire [WAW-1:0] win_raddr = map_w.comp ? WAW'(2 * WIN_HALF) + WAW'(map_w.widx)
                                        : WAW'(map_w.widx);
  wire run_w = state_q == mwola_pkg::MWOLA_RUN;
  wire [FAW-1:0] frame_raddr = FAW'(map_w.src);
  wire [FAW-1:0] frame_waddr = FAW'(cnt_q);

  logic [SW-1:0] frame_rd;
  logic [mwola_pkg::COEF_W-1:0] win_rd;
  logic [SW-1:0] ovl_rd;

  mwola_mem #(.WIDTH(SW), .DEPTH(FRAME_MAX)) u_frame (
    .clock_i(clock_i),
    .we_i(in_valid_i && in_ready_o),
    .waddr_i(frame_waddr),
    .wdata_i(in_data_i),
    .raddr_i(frame_raddr),
    .rdata_o(frame_rd)
  );

  mwola_mem #(.WIDTH(mwola_pkg::COEF_W), .DEPTH(WIN_DEPTH)) u_window (
    .clock_i(clock_i),
    .we_i(win_we_i),
    .waddr_i(win_addr_i),
    .wdata_i(win_data_i),
    .raddr_i(win_raddr),
    .rdata_o(win_rd)
  );

  // stage 1: window product with sign, then overlap-add or store
  // operands widened first so the full 32-bit product survives the shift
  wire signed [AW-1:0] prod = (AW'(signed'(frame_rd)) * AW'(signed'(win_rd)))
                              >>> mwola_pkg::COEF_FRAC;
  wire signed [AW-1:0] term = neg1_q ? -prod : prod;
  wire [SW-1:0] raw_w = neg1_q ? SW'(-signed'(frame_rd)) : frame_rd;
  wire first_half = k1_q < len_q;
  wire [IW-1:0] ovl_idx = k1_q - len_q;
  wire [SW-1:0] ola_w = sat(term + AW'(signed'(ovl_rd)));
  wire clr_w = state_q == mwola_pkg::MWOLA_CLEAR;
  wire ovl_we = clr_w || (v1_q && !first_half);
  wire [FAW-1:0] ovl_waddr = clr_w ? FAW'(cnt_q) : FAW'(ovl_idx);
  wire [SW-1:0] ovl_wdata = clr_w ? '0 : sat(term);

  mwola_mem #(.WIDTH(SW), .DEPTH(FRAME_MAX)) u_overlap (
    .clock_i(clock_i),
    .we_i(ovl_we),
    .waddr_i(ovl_waddr),
    .wdata_i(ovl_wdata),
    .raddr_i(FAW'(cnt_q)),
    .rdata_o(ovl_rd)
  );

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      v1_q <= 1'b0;
      neg1_q <= 1'b0;
      k1_q <= '0;
      v2_q <= 1'b0;
      ola_q <= '0;
      premem_valid_o <= 1'b0;
      premem_data_o <= '0;
    end else begin
      v1_q <= run_w;
      neg1_q <= map_w.neg;
      k1_q <= cnt_q;
      v2_q <= v1_q && first_half;
      if (v1_q && first_half) ola_q <= ola_w;
      // unwindowed head of the next frame's memory
      premem_valid_o <= v1_q && !first_half && ovl_idx < premem_len;
      if (v1_q && !first_half) premem_data_o <= raw_w;
    end
  end

  // stage 2: two-band split on a causal 1-2-1 low pass, scale, recombine
  assign gain_req_o = v2_q;
  assign gain_sample_o = ola_q;
  wire signed [AW-1:0] lb = (AW'(signed'(ola_q)) + 2 * AW'(signed'(hist1_q))
                             + AW'(signed'(hist2_q))) >>> 2;
  wire signed [AW-1:0] hb = AW'(signed'(ola_q)) - lb;
  wire zone_w = atten_en_o && echo_zone_i;
  wire [mwola_pkg::COEF_W-1:0] g_lb = zone_w ? gain_lb_i
                                             : mwola_pkg::GAIN_UNITY;
  wire [mwola_pkg::COEF_W-1:0] g_hb = zone_w ? gain_hb_i
                                             : mwola_pkg::GAIN_UNITY;
  wire signed [AW-1:0] lb_s = AW'((lb * AW'(signed'({1'b0, g_lb})))
                                  >>> mwola_pkg::COEF_FRAC);
  wire signed [AW-1:0] hb_s = AW'((hb * AW'(signed'({1'b0, g_hb})))
                                  >>> mwola_pkg::COEF_FRAC);
  wire [SW-1:0] att_w = sat(lb_s + hb_s);

  // outside echo zones the sample passes untouched, not via unity gains
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      hist1_q <= '0;
      hist2_q <= '0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      out_valid_o <= v2_q;
      if (v2_q) begin
        hist1_q <= ola_q;
        hist2_q <= hist1_q;
        out_data_o <= zone_w ? att_w : ola_q;
      end
    end
  end
endmodule : mwola_unfold

`default_nettype wire

/* File: bench/mwola_chk.sv */
`timescale 1ns/1ns
`default_nettype none

module mwola_chk (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // watched inputs
  input wire logic [15:0] frame_len_i,
  input wire logic frame_good_i,
  input wire logic bitrate_low_i,
  input wire logic in_valid_i,
  // watched outputs
  input wire logic in_ready_o,
  input wire logic premem_valid_o,
  input wire logic gain_req_o,
  input wire logic out_valid_o,
  input wire logic atten_en_o
);
  logic [15:0] cnt_q;
  logic [15:0] tk_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // length of the current output burst
  always_ff @(posedge clock_i) begin
    if (!out_valid_o)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_q + 16'h0001;
  end

  // samples taken in this load phase
  always_ff @(posedge clock_i) begin
    if (!in_ready_o)
      tk_q <= 16'h0000;
    else if (in_valid_i)
      tk_q <= tk_q + 16'h0001;
  end

  burst_len_a: assert property (
    $fell(out_valid_o) |-> cnt_q == frame_len_i)
    else $error("output burst length wrong");
  clear_wait_a: assert property (
    $rose(reset_n_i) |-> !in_ready_o [*4])
    else $error("input accepted while clearing");
  gain_out_a: assert property (
    gain_req_o |=> out_valid_o)
    else $error("no output after gain request");
  // the last output and the first look-ahead pulse share a cycle
  premem_gap_a: assert property (
    premem_valid_o |-> !gain_req_o && !in_ready_o)
    else $error("look-ahead sample out of place");
  run_start_a: assert property (
    $fell(in_ready_o) |-> ##3 out_valid_o)
    else $error("first output late");
  no_take_a: assert property (
    out_valid_o |-> !in_ready_o)
    else $error("input open while emitting");
  atten_cause_a: assert property (
    $rose(atten_en_o) |-> frame_good_i && bitrate_low_i)
    else $error("attenuation enabled without cause");
  ready_len_a: assert property (
    in_valid_i && in_ready_o && tk_q == frame_len_i - 16'h0001
    |=> !in_ready_o)
    else $error("input still open after full frame");
endmodule : mwola_chk

`default_nettype wire

/* File: bench/mwola_src.sv */
`timescale 1ns/1ns
`default_nettype none

// inverse transform stage: sends one frame per start pulse
module mwola_src (
  // clock and control
  input wire logic clock_i,
  input wire logic start_i,
  input wire logic slow_i,
  input wire logic [15:0] len_i,
  input wire logic [15:0] seed_i,
  // sample stream
  output logic in_valid_o,
  output logic [15:0] in_data_o,
  input wire logic in_ready_i
);
  // even samples with alternating sign keep the half window exact
  initial begin
    in_valid_o = 1'b0;
    in_data_o = 16'h5a5a;
    forever begin
      @(posedge clock_i);
      if (start_i) begin
        for (int i = 0; i < int'(len_i); i++) begin
          if (slow_i) begin
            #1 in_valid_o = 1'b0;
            in_data_o = ~in_data_o;
            repeat (2) @(posedge clock_i);
          end
          #1 in_valid_o = 1'b1;
          in_data_o = 16'((i % 2) ? -(seed_i + 4 * i) : seed_i + 4 * i);
          // ready is sampled mid-cycle to dodge the edge race
          @(negedge clock_i);
          while (in_ready_i !== 1'b1) @(negedge clock_i);
          @(posedge clock_i);
        end
        // released data is not left looking valid
        #1 in_valid_o = 1'b0;
        in_data_o = ~in_data_o;
      end
    end
  end
endmodule : mwola_src

`default_nettype wire

/* File: bench/mdct_unfold_window_overlap_add_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module mdct_unfold_window_overlap_add_tb;
  localparam int L = 8;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [15:0] frame_len_i = 16'h0008;
  logic [3:0] dec_step_i = 4'h1;
  logic [3:0] dec_offset_i = 4'h0;
  logic rate32_i = 1'b0;
  logic frame_good_i = 1'b0;
  logic bitrate_low_i = 1'b0;
  logic win_we_i = 1'b0;
  logic [4:0] win_addr_i = 5'h00;
  logic [15:0] win_data_i = 16'h0000;
  logic echo_zone_i = 1'b0;
  logic [15:0] gain_g = mwola_pkg::GAIN_UNITY;
  logic [15:0] pmd = 16'h0000;
  logic [15:0] gq[$];
  logic in_valid_i, in_ready_o, premem_valid_o, gain_req_o, out_valid_o;
  logic [15:0] in_data_i, premem_data_o, gain_sample_o, out_data_o;
  logic atten_en_o;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic pv = 1'b0;
  logic pg = 1'b0;
  logic [15:0] seed = 16'h0000;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int npm = 0;
  int ps = 0;
  logic [15:0] outq[$];

  // 20 MHz clock
  always #25 clock_i = ~clock_i;

  mwola_unfold #(.FRAME_MAX(8), .WIN_HALF(8), .COMP_DEPTH(8)) DUT (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .frame_len_i(frame_len_i),
    .dec_step_i(dec_step_i), .dec_offset_i(dec_offset_i),
    .rate32_i(rate32_i), .frame_good_i(frame_good_i),
    .bitrate_low_i(bitrate_low_i), .win_we_i(win_we_i),
    .win_addr_i(win_addr_i), .win_data_i(win_data_i),
    .in_valid_i(in_valid_i), .in_data_i(in_data_i), .in_ready_o(in_ready_o),
    .premem_valid_o(premem_valid_o), .premem_data_o(premem_data_o),
    .gain_req_o(gain_req_o), .gain_sample_o(gain_sample_o),
    .echo_zone_i(echo_zone_i), .gain_lb_i(gain_g),
    .gain_hb_i(gain_g), .out_valid_o(out_valid_o),
    .out_data_o(out_data_o), .atten_en_o(atten_en_o));

  mwola_src src (.clock_i(clock_i), .start_i(start), .slow_i(slow),
    .len_i(frame_len_i), .seed_i(seed), .in_valid_o(in_valid_i),
    .in_data_o(in_data_i), .in_ready_i(in_ready_o));

  // outputs are registered, so collect them at the falling edge
  always @(negedge clock_i) begin
    if (out_valid_o === 1'b1) outq.push_back(out_data_o);
    if (gain_req_o === 1'b1) gq.push_back(gain_sample_o);
    if (premem_valid_o === 1'b1) begin
      npm++;
      pmd = premem_data_o;
    end
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      finish_test();
    end
  end

  function automatic int xs(int s, int i);
    return (i % 2) ? -(s + 4 * i) : s + 4 * i;
  endfunction : xs

  // block sample with every window coefficient at one half
  function automatic int blk(int j, int s);
    int n;
    n = j % (L / 2);
    case (j / (L / 2))
      0: return xs(s, L / 2 + n) / 2;
      // at 32 kHz the odd samples of this quarter sit one place later
      1: return -xs(s, L - n - 1 + int'(rate32_i && n % 2 == 1)) / 2;
      2: return -xs(s, L / 2 - n - 1) / 2;
      default: return -xs(s, n) / 2;
    endcase
  endfunction : blk

  task automatic check(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      num_errors++;
    end
  endtask : check

  task automatic do_reset();
    int w;
    reset_n_i = 1'b0;
    repeat (8) @(posedge clock_i);
    #1 reset_n_i = 1'b1;
    pv = 1'b0;
    pg = 1'b0;
    w = 0;
    while (in_ready_o !== 1'b1 && w < 50) begin
      @(posedge clock_i);
      #1 w++;
    end
    check(16'(w >= 7 && w < 50), 16'h0001);
    $display("reset done");
  endtask : do_reset

  task automatic load_win();
    for (int a = 0; a < 24; a++) begin
      win_we_i = 1'b1;
      win_addr_i = 5'(a);
      win_data_i = 16'h4000;
      @(posedge clock_i);
      #1;
    end
    win_we_i = 1'b0;
  endtask : load_win

  task automatic run_frame(input int s, input logic g, input logic lo,
      input logic sl, input logic ez);
    int w;
    logic [15:0] e;
    logic zn;
    outq.delete();
    gq.delete();
    npm = 0;
    seed = 16'(s);
    frame_good_i = g;
    bitrate_low_i = lo;
    slow = sl;
    echo_zone_i = ez;
    // zero gains make an attenuated zone plainly visible
    gain_g = ez ? 16'h0000 : mwola_pkg::GAIN_UNITY;
    start = 1'b1;
    @(posedge clock_i);
    #1 start = 1'b0;
    w = 0;
    while (outq.size() < L && w < 300) begin
      @(posedge clock_i);
      #1 w++;
    end
    repeat (2 * L + 4) @(posedge clock_i);
    #1 check(16'(L), 16'(outq.size()));
    check(16'(L), 16'(gq.size()));
    zn = g & pg & lo & ez;
    for (int n = 0; n < L && n < outq.size(); n++) begin
      e = 16'(blk(n, s) + (pv ? blk(n + L, ps) : 0));
      check(zn ? 16'h0000 : e, outq[n]);
      check(e, gq[n]);
    end
    check(16'((7 * L) / 32), 16'(npm));
    check(16'(-xs(s, L / 2 - 1)), pmd);
    check({15'h0000, g & pg & lo}, {15'h0000, atten_en_o});
    pg = g;
    pv = 1'b1;
    ps = s;
    $display("frame %h done", s);
  endtask : run_frame

  // reset while outputs stream, then the overlap must start from zero
  task automatic mid_reset();
    int w;
    outq.delete();
    seed = 16'h0070;
    start = 1'b1;
    @(posedge clock_i);
    #1 start = 1'b0;
    w = 0;
    while (outq.size() < 2 && w < 300) begin
      @(posedge clock_i);
      #1 w++;
    end
    do_reset();
    run_frame(16'h0080, 1'b1, 1'b1, 1'b0, 1'b0);
  endtask : mid_reset

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  initial begin
    #1 do_reset();
    load_win();
    run_frame(16'h0010, 1'b1, 1'b1, 1'b0, 1'b0);
    run_frame(16'h0020, 1'b1, 1'b1, 1'b1, 1'b0);
    run_frame(16'h0030, 1'b1, 1'b0, 1'b0, 1'b1);
    run_frame(16'h0040, 1'b0, 1'b1, 1'b0, 1'b0);
    run_frame(16'h0050, 1'b1, 1'b1, 1'b1, 1'b0);
    run_frame(16'h0060, 1'b1, 1'b1, 1'b0, 1'b0);
    run_frame(16'h0064, 1'b1, 1'b1, 1'b0, 1'b1);
    rate32_i = 1'b1;
    run_frame(16'h0068, 1'b1, 1'b1, 1'b0, 1'b0);
    rate32_i = 1'b0;
    mid_reset();
    finish_test();
  end
endmodule : mdct_unfold_window_overlap_add_tb

bind mwola_unfold mwola_chk u_chk (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .frame_len_i(frame_len_i),
  .frame_good_i(frame_good_i), .bitrate_low_i(bitrate_low_i),
  .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
  .premem_valid_o(premem_valid_o), .gain_req_o(gain_req_o),
  .out_valid_o(out_valid_o), .atten_en_o(atten_en_o));

`default_nettype wire
